// *** verilog/mit_ctrl.sv ***
// Purpose: interrupt flags, enables, priority vectoring, wake-up and time bases
// Assumes: CPU core offers next-pc and a take strobe; peripherals give 1-cycle events
// Notes: AHB-Lite slave with zero wait states, always OKAY
`timescale 1ns/100ps
`default_nettype none
module mit_ctrl
  import mit_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] ext_irq_pin,
  input wire logic [1:0] counter_overflow,
  input wire logic [3:0] usb_condition,
  input wire logic frame_start,
  input wire logic serial_done,
  input wire logic sub_clk,
  input wire logic [MIT_PC_W-1:0] next_pc,
  input wire logic cpu_take_ok,
  input wire logic return_from_irq_instr,
  input wire logic sleep_enter,
  output logic [MIT_PC_W-1:0] pc_load_value,
  output logic pc_load,
  output logic wake
);
  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] rd_addr;
  logic [1:0] pin_edge_select_reg_ff;
  logic [1:0] pin1_edge_ff;
  logic global_irq_enable_ff;
  logic [MIT_NSRC-1:0] en_ff;
  logic [MIT_NSRC-1:0] flag_ff;
  logic [1:0] prescaler_source_field_ff;
  logic [7:0] tick0_control_ff;
  logic [7:0] tick1_control_ff;
  logic [31:0] hrdata_ff;
  logic serial_flag_ff, serial_enable_ff;
  mit_state_e state_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= MIT_RST_REG;
    end else if (hready) begin
      wr_pend_ff <= hsel && htrans[1] && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  assign rd_addr = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (rd_addr)
        MIT_OFF_EDGE: hrdata_ff <= {28'h0, pin1_edge_ff, pin_edge_select_reg_ff};
        MIT_OFF_CTL0: hrdata_ff <= {25'h0, flag_ff[2:0], en_ff[2:0], global_irq_enable_ff};
        MIT_OFF_CTL1: hrdata_ff <= {24'h0, flag_ff[5:4], 2'h0, en_ff[5:4], 2'h0};
        MIT_OFF_CTL2: hrdata_ff <= {25'h0, flag_ff[7:6], 2'h0, en_ff[7:6], 1'b0};
        MIT_OFF_CTL3: hrdata_ff <= {26'h0, flag_ff[3], serial_flag_ff, 2'h0,
          en_ff[3], serial_enable_ff};
        MIT_OFF_PSC: hrdata_ff <= {30'h0, prescaler_source_field_ff};
        MIT_OFF_TB0: hrdata_ff <= {24'h0, tick0_control_ff};
        MIT_OFF_TB1: hrdata_ff <= {24'h0, tick1_control_ff};
        MIT_OFF_STAT: hrdata_ff <= {31'h0, state_ff == MIT_ST_SLEEP};
        default: hrdata_ff <= '0;
      endcase
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  logic wr_edge, wr_c0, wr_c1, wr_c2, wr_c3;
  assign wr_edge = wr_pend_ff && (wr_addr_ff == MIT_OFF_EDGE);
  assign wr_c0 = wr_pend_ff && (wr_addr_ff == MIT_OFF_CTL0);
  assign wr_c1 = wr_pend_ff && (wr_addr_ff == MIT_OFF_CTL1);
  assign wr_c2 = wr_pend_ff && (wr_addr_ff == MIT_OFF_CTL2);
  assign wr_c3 = wr_pend_ff && (wr_addr_ff == MIT_OFF_CTL3);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_edge_select_reg_ff <= MIT_EDGE_OFF;
      pin1_edge_ff <= MIT_EDGE_OFF;
      prescaler_source_field_ff <= MIT_PSC_SYS;
      tick0_control_ff <= MIT_RST_REG;
      tick1_control_ff <= MIT_RST_REG;
    end else if (wr_pend_ff) begin
      if (wr_edge) begin
        pin_edge_select_reg_ff <= hwdata[1:0];
        pin1_edge_ff <= hwdata[3:2];
      end
      if (wr_addr_ff == MIT_OFF_PSC) begin
        prescaler_source_field_ff <= hwdata[1:0];
      end
      if (wr_addr_ff == MIT_OFF_TB0) begin
        tick0_control_ff <= {hwdata[7], 4'h0, hwdata[2:0]};
      end
      if (wr_addr_ff == MIT_OFF_TB1) begin
        tick1_control_ff <= {hwdata[7], 4'h0, hwdata[2:0]};
      end
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  logic [1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic [1:0] pin_lvl_ff;
  logic [1:0] pin_hit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= ext_irq_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // stable level changes only when second and third stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_lvl_ff <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) begin
          pin_lvl_ff[i] <= pin_s3_ff[i];
        end
      end
    end
  end

  // pull-ups live in the port block; nothing here alters them
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      logic [1:0] sel;
      logic rise, fall;
      assign sel = (g == 0) ? pin_edge_select_reg_ff : pin1_edge_ff;
      assign rise = (pin_s2_ff[g] == pin_s3_ff[g]) && pin_s3_ff[g] && !pin_lvl_ff[g];
      assign fall = (pin_s2_ff[g] == pin_s3_ff[g]) && !pin_s3_ff[g] && pin_lvl_ff[g];
      assign pin_hit[g] = ((sel == MIT_EDGE_RISE) && rise)
        || ((sel == MIT_EDGE_FALL) && fall)
        || ((sel == MIT_EDGE_BOTH) && (rise || fall));
    end
  endgenerate

  // ------------------------------------------------------------
  // time base prescaler and dividers
  // ------------------------------------------------------------
  logic [2:0] sub_s_ff;
  logic sub_lvl_ff;
  logic sub_tick;
  logic [1:0] div4_ff;
  logic psc_tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_s_ff <= '0;
      sub_lvl_ff <= 1'b0;
      div4_ff <= '0;
    end else begin
      sub_s_ff <= {sub_s_ff[1:0], sub_clk};
      if (sub_s_ff[1] == sub_s_ff[2]) begin
        sub_lvl_ff <= sub_s_ff[2];
      end
      div4_ff <= div4_ff + 2'h1;
    end
  end

  assign sub_tick = (sub_s_ff[1] == sub_s_ff[2]) && sub_s_ff[2] && !sub_lvl_ff;

  always_comb begin
    if (prescaler_source_field_ff[1]) begin
      psc_tick = sub_tick;
    end else if (prescaler_source_field_ff == MIT_PSC_DIV4) begin
      psc_tick = (div4_ff == MIT_DIV4_LAST);
    end else begin
      psc_tick = 1'b1;
    end
  end

  logic [1:0] tick_hit;
  generate
    for (g = 0; g < 2; g++) begin : g_tb
      logic [MIT_TB_W-1:0] cnt_ff;
      logic [7:0] ctl;
      logic [MIT_TB_W-1:0] last;
      assign ctl = (g == 0) ? tick0_control_ff : tick1_control_ff;
      assign last = MIT_TB_W'((32'h1 << (MIT_TB_BASE + int'(ctl[2:0]))) - 1);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_ff <= '0;
        end else if (!ctl[MIT_TB_RUN_BIT]) begin
          cnt_ff <= '0;
        end else if (psc_tick) begin
          cnt_ff <= (cnt_ff >= last) ? '0 : cnt_ff + 1'b1;
        end
      end
      assign tick_hit[g] = ctl[MIT_TB_RUN_BIT] && psc_tick && (cnt_ff >= last);
    end
  endgenerate

  // ------------------------------------------------------------
  // flags, enables and vectoring
  // ------------------------------------------------------------
  mit_stack_if st();
  logic [MIT_NSRC-1:0] raw_evt;
  logic [MIT_NSRC-1:0] pend;
  logic [MIT_NSRC-1:0] svc_clr;
  logic [MIT_NSRC-1:0] nxt_flag;
  logic [MIT_NSRC-1:0] sw_wr, sw_val;
  logic any_pend;
  logic take;
  logic [2:0] win;

  assign raw_evt = {counter_overflow, tick_hit, frame_start, |usb_condition, pin_hit};
  // serial source has no vector slot; its flag only wakes and reads back

  assign pend = flag_ff & en_ff;
  assign any_pend = |pend;
  assign take = any_pend && global_irq_enable_ff && !st.full && cpu_take_ok;

  always_comb begin
    win = 3'h0;
    for (int i = MIT_NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win = 3'(i);
      end
    end
  end

  always_comb begin
    svc_clr = '0;
    if (take) begin
      svc_clr[win] = 1'b1;
    end
  end

  always_comb begin
    sw_wr = '0;
    sw_val = '0;
    if (wr_c0) begin
      sw_wr[2:0] = 3'h7;
      sw_val[2:0] = hwdata[6:4];
    end
    if (wr_c1) begin
      sw_wr[5:4] = 2'h3;
      sw_val[5:4] = hwdata[7:6];
    end
    if (wr_c2) begin
      sw_wr[7:6] = 2'h3;
      sw_val[7:6] = hwdata[6:5];
    end
    if (wr_c3) begin
      sw_wr[3] = 1'b1;
      sw_val[3] = hwdata[5];
    end
  end

  // event wins over a clear in the same cycle
  assign nxt_flag = raw_evt | (sw_wr & sw_val) | (flag_ff & ~sw_wr & ~svc_clr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= '0;
      en_ff <= '0;
      serial_flag_ff <= 1'b0;
      serial_enable_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      if (wr_c0) en_ff[2:0] <= hwdata[3:1];
      if (wr_c1) en_ff[5:4] <= hwdata[3:2];
      if (wr_c2) en_ff[7:6] <= hwdata[2:1];
      if (wr_c3) en_ff[3] <= hwdata[1];
      serial_flag_ff <= serial_done || (wr_c3 ? hwdata[4] : serial_flag_ff);
      if (wr_c3) serial_enable_ff <= hwdata[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_irq_enable_ff <= 1'b0;
    end else if (take) begin
      global_irq_enable_ff <= 1'b0;
    end else if (return_from_irq_instr && !st.empty) begin
      global_irq_enable_ff <= 1'b1;
    end else if (wr_c0) begin
      global_irq_enable_ff <= hwdata[0];
    end
  end

  assign st.push = take;
  assign st.wdata = next_pc;
  assign st.pop = return_from_irq_instr && !st.empty && !take;

  mit_stack u_stack (
    .hclk(hclk),
    .hresetn(hresetn),
    .st(st)
  );

  logic ret_d_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_load <= 1'b0;
      pc_load_value <= '0;
      ret_d_ff <= 1'b0;
    end else begin
      ret_d_ff <= st.pop;
      pc_load <= take || st.pop;
      if (take) begin
        pc_load_value <= MIT_VEC_BASE + MIT_VEC_STEP * 13'(win);
      end else if (st.pop) begin
        pc_load_value <= st.rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // sleep and wake
  // ------------------------------------------------------------
  logic [MIT_NSRC:0] all_flags;
  logic rise_any;
  assign all_flags = {serial_flag_ff, flag_ff};
  assign rise_any = |({serial_done, raw_evt} & ~all_flags);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= MIT_ST_RUN;
      wake <= 1'b0;
    end else begin
      wake <= 1'b0;
      case (state_ff)
        MIT_ST_RUN: begin
          if (sleep_enter) state_ff <= MIT_ST_SLEEP;
        end
        MIT_ST_SLEEP: begin
          if (rise_any) begin
            state_ff <= MIT_ST_RUN;
            wake <= 1'b1;
          end
        end
        default: state_ff <= MIT_ST_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_push_loads_vec: assert property (@(posedge hclk) disable iff (!hresetn)
    take |=> pc_load && pc_load_value == MIT_VEC_BASE + MIT_VEC_STEP * 13'($past(win)))
    else $error("vector load missing");
  a_take_clears_gie: assert property (@(posedge hclk) disable iff (!hresetn)
    take |=> !global_irq_enable_ff) else $error("global enable not cleared");
  a_full_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
    st.full |-> !take) else $error("took while stack full");
  a_need_enables: assert property (@(posedge hclk) disable iff (!hresetn)
    take |-> global_irq_enable_ff && en_ff[win] && flag_ff[win]) else $error("take without enable");
  a_flag_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    flag_ff[2] && !en_ff[2] && !wr_c0 |=> flag_ff[2]) else $error("disabled flag lost");
  a_event_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    raw_evt[6] |=> flag_ff[6]) else $error("counter flag not set");
  a_svc_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !raw_evt[win] |=> !flag_ff[$past(win)]) else $error("flag not cleared");
  sequence s_wake_pulse;
    wake ##1 !wake;
  endsequence
  a_wake_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == MIT_ST_SLEEP && rise_any |=> s_wake_pulse) else $error("no wake");
  a_ret_pops: assert property (@(posedge hclk) disable iff (!hresetn)
    st.pop |=> pc_load && pc_load_value == $past(st.rdata)) else $error("bad return");
endmodule
`default_nettype wire

// *** verilog/mit_pkg.sv ***
// Purpose: shared constants for the interrupt and time base block
// Assumes: 32-bit AHB-Lite register bus, 25 MHz hclk
// Notes: offsets are byte addresses of word registers
`default_nettype none
package mit_pkg;
  localparam logic [7:0] MIT_OFF_EDGE = 8'h00;
  localparam logic [7:0] MIT_OFF_CTL0 = 8'h04;
  localparam logic [7:0] MIT_OFF_CTL1 = 8'h08;
  localparam logic [7:0] MIT_OFF_CTL2 = 8'h0C;
  localparam logic [7:0] MIT_OFF_CTL3 = 8'h10;
  localparam logic [7:0] MIT_OFF_PSC = 8'h14;
  localparam logic [7:0] MIT_OFF_TB0 = 8'h18;
  localparam logic [7:0] MIT_OFF_TB1 = 8'h1C;
  localparam logic [7:0] MIT_OFF_STAT = 8'h20;
  localparam logic [7:0] MIT_RST_REG = 8'h00;
  localparam int MIT_NSRC = 8;
  localparam int MIT_PC_W = 13;
  localparam int MIT_STACK_DEPTH = 8;
  localparam int MIT_SP_W = 4;
  localparam int MIT_TB_W = 15;
  localparam int MIT_TB_BASE = 8;
  localparam int MIT_TB_RUN_BIT = 7;
  localparam logic [1:0] MIT_EDGE_OFF = 2'h0;
  localparam logic [1:0] MIT_EDGE_RISE = 2'h1;
  localparam logic [1:0] MIT_EDGE_FALL = 2'h2;
  localparam logic [1:0] MIT_EDGE_BOTH = 2'h3;
  localparam logic [1:0] MIT_PSC_SYS = 2'h0;
  localparam logic [1:0] MIT_PSC_DIV4 = 2'h1;
  localparam logic [1:0] MIT_DIV4_LAST = 2'h3;
  // source index: 0 pin0, 1 pin1, 2 usb, 3 sof, 4 tick0, 5 tick1, 6 cnt0, 7 cnt1
  // vector addresses, index 0 has highest priority
  localparam logic [12:0] MIT_VEC_BASE = 13'h0004;
  localparam logic [12:0] MIT_VEC_STEP = 13'h0004;
  typedef enum logic [1:0] {MIT_ST_RUN, MIT_ST_SLEEP} mit_state_e;
endpackage
`default_nettype wire

// *** verilog/mit_stack_if.sv ***
// Purpose: carrier between the controller and its return-address stack
// Assumes: one clock domain
// Notes: push and pop are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface mit_stack_if;
  import mit_pkg::*;
  logic push;
  logic pop;
  logic [MIT_PC_W-1:0] wdata;
  logic [MIT_PC_W-1:0] rdata;
  logic full;
  logic empty;
  modport ctrl (output push, output pop, output wdata, input rdata, input full, input empty);
  modport mem (input push, input pop, input wdata, output rdata, output full, output empty);
endinterface
`default_nettype wire

// *** verilog/mit_stack.sv ***
// Purpose: return-address stack memory
// Assumes: controller never pushes while full nor pops while empty
// Notes: read data is registered top-of-stack
`timescale 1ns/100ps
`default_nettype none
module mit_stack
  import mit_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  mit_stack_if.mem st
);
  logic [MIT_PC_W-1:0] mem_ff [MIT_STACK_DEPTH];
  logic [MIT_SP_W-1:0] sp_ff;
  logic [MIT_PC_W-1:0] top_ff;

  always_ff @(posedge hclk) begin
    if (st.push) begin
      mem_ff[sp_ff[MIT_SP_W-2:0]] <= st.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_ff <= '0;
      top_ff <= '0;
    end else if (st.push) begin
      sp_ff <= sp_ff + 4'h1;
      top_ff <= st.wdata;
    end else if (st.pop) begin
      sp_ff <= sp_ff - 4'h1;
      // top_ff holds the popped value during this cycle
      top_ff <= (sp_ff >= 4'h2) ? mem_ff[3'(sp_ff - 4'h2)] : '0;
    end
  end

  assign st.rdata = top_ff;
  assign st.full = (sp_ff == 4'(MIT_STACK_DEPTH));
  assign st.empty = (sp_ff == 4'h0);
endmodule
`default_nettype wire

// *** testbench/mit_core_model.sv ***
// Purpose: stand-in for the core's program counter and return logic
// Assumes: pc holds still between loads, so every saved pc is known
// Notes: slow mode grants cpu_take_ok one cycle in four
`timescale 1ns/100ps
`default_nettype none
module mit_core_model
  import mit_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic ret_req,
  input wire logic pc_load,
  input wire logic [MIT_PC_W-1:0] pc_load_value,
  output logic [MIT_PC_W-1:0] next_pc,
  output logic cpu_take_ok,
  output logic return_from_irq_instr,
  output int n_load
);
  // ------------------------------
  // pc register and grant pacing
  // ------------------------------
  logic [1:0] ph_ff;
  // a stalling core must not lose the request, only delay it
  // no grant while a load is landing: the pc to save is not there yet
  assign cpu_take_ok = !pc_load && (slow ? (ph_ff == 2'h3) : 1'b1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_ff <= 2'h0;
      next_pc <= 13'h0123;
      n_load <= 0;
      return_from_irq_instr <= 1'b0;
    end else begin
      ph_ff <= ph_ff + 2'h1;
      return_from_irq_instr <= ret_req;
      if (pc_load) begin
        next_pc <= pc_load_value;
        n_load <= n_load + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/mit_tb_top.sv ***
// Purpose: self-checking bench for the interrupt and time base block
// Assumes: zero-wait bus slave, core model with a frozen pc
// Notes: tick periods are found by polling, so a few cycles of slack
`timescale 1ns/100ps
`default_nettype none
module mit_tb_top
  import mit_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, ext_irq_pin, counter_overflow;
  logic [2:0] hsize;
  logic [3:0] usb_condition;
  logic frame_start, serial_done, sub_clk, sleep_enter, slow, ret_req;
  logic cpu_take_ok, return_from_irq_instr, pc_load, wake;
  logic [MIT_PC_W-1:0] next_pc, pc_load_value;
  int n_fail = 0;
  int total_checks = 0;
  int n_load;
  int n_wake = 0;
  int seen = 0;
  assign hready = hreadyout;
  mit_ctrl u_mit_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin(ext_irq_pin),
    .counter_overflow(counter_overflow), .usb_condition(usb_condition),
    .frame_start(frame_start), .serial_done(serial_done), .sub_clk(sub_clk),
    .next_pc(next_pc), .cpu_take_ok(cpu_take_ok),
    .return_from_irq_instr(return_from_irq_instr), .sleep_enter(sleep_enter),
    .pc_load_value(pc_load_value), .pc_load(pc_load), .wake(wake));
  mit_core_model u_mit_core_model (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .ret_req(ret_req), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .next_pc(next_pc), .cpu_take_ok(cpu_take_ok),
    .return_from_irq_instr(return_from_irq_instr), .n_load(n_load));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // subclock unrelated to hclk, 16 cycles a period
  initial begin
    sub_clk = 1'b0;
    forever #320 sub_clk = ~sub_clk;
  end
  always @(posedge hclk) begin
    if (wake === 1'b1) begin
      n_wake++;
    end
  end
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %0h want %0h", $time, s, got, exp);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      n_fail++;
      $display("BAD %0t wait ran out", $time);
      close_out();
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    tmo(n, 20);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response okay");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string s);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e, s);
  endtask
  // one-cycle pulse on {sleep, return, cnt1..0, usb3..0, frame, serial}
  task automatic evp(input logic [9:0] v);
    @(posedge hclk);
    {sleep_enter, ret_req, counter_overflow, usb_condition, frame_start, serial_done} <= v;
    @(posedge hclk);
    {sleep_enter, ret_req, counter_overflow, usb_condition, frame_start, serial_done} <= 10'h000;
  endtask
  task automatic wait_load(input logic [12:0] exp);
    int n;
    n = 0;
    while (n_load == seen && n < 60) begin
      @(posedge hclk);
      n++;
    end
    tmo(n, 60);
    chk({19'h0, next_pc}, {19'h0, exp}, "pc loaded");
    seen++;
  endtask
  task automatic no_load;
    repeat (15) @(posedge hclk);
    chk(32'(n_load - seen), 32'h0, "unexpected vector");
  endtask
  task automatic pin(input logic [1:0] v);
    @(posedge hclk);
    ext_irq_pin <= v;
    // three-flop synchroniser plus margin
    repeat (6) @(posedge hclk);
  endtask
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      bus(1'b0, MIT_OFF_CTL1, 32'h0);
      n++;
    end while ((rd & m) !== m && n < 8000);
    tmo(n, 8000);
  endtask
  task automatic tmeas(input logic [7:0] off, input logic [1:0] ps, input logic [2:0] rt,
                       input logic [31:0] m, input int exp);
    realtime t0;
    int d;
    wr(MIT_OFF_PSC, {30'h0, ps});
    wr(off, {24'h0, 5'h10, rt});
    wr(MIT_OFF_CTL1, 32'h0);
    poll(m);
    t0 = $realtime;
    wr(MIT_OFF_CTL1, 32'h0);
    poll(m);
    d = int'(($realtime - t0) / 40.0);
    total_checks++;
    if (d < exp - 6 || d > exp + 6) begin
      n_fail++;
      $display("BAD %0t tick period %0d want %0d", $time, d, exp);
    end
    wr(off, 32'h0);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_regs;
    rdm(MIT_OFF_PSC, 32'hFF, 32'h00, "psc reset");
    rdm(MIT_OFF_TB0, 32'hFF, 32'h00, "tb0 reset");
    rdm(MIT_OFF_TB1, 32'hFF, 32'h00, "tb1 reset");
    wr(MIT_OFF_PSC, 32'hFF);
    rdm(MIT_OFF_PSC, 32'hFF, 32'h03, "psc bits");
    wr(MIT_OFF_TB1, 32'hFF);
    rdm(MIT_OFF_TB1, 32'hFF, 32'h87, "tick bits");
    wr(8'h40, 32'hFF);
    rdm(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    wr(MIT_OFF_PSC, 32'h0);
    wr(MIT_OFF_TB1, 32'h0);
  endtask
  task automatic t_edge;
    for (int m = 0; m < 4; m++) begin
      wr(MIT_OFF_EDGE, 32'(m * 5));
      wr(MIT_OFF_CTL0, 32'h06);
      pin(2'h3);
      rdm(MIT_OFF_CTL0, 32'h30, m[0] ? 32'h30 : 32'h0, "rising edge");
      wr(MIT_OFF_CTL0, 32'h06);
      pin(2'h0);
      rdm(MIT_OFF_CTL0, 32'h30, m[1] ? 32'h30 : 32'h0, "falling edge");
    end
  endtask
  task automatic t_usb;
    for (int k = 0; k < 4; k++) begin
      wr(MIT_OFF_CTL0, 32'h0);
      evp(10'h004 << k);
      rdm(MIT_OFF_CTL0, 32'h40, 32'h40, "usb condition");
    end
    evp(10'h001);
    rdm(MIT_OFF_CTL3, 32'h10, 32'h10, "serial flag");
  endtask
  task automatic t_vec;
    wr(MIT_OFF_CTL0, 32'h08);
    wr(MIT_OFF_CTL2, 32'h02);
    evp(10'h044);
    no_load();
    rdm(MIT_OFF_CTL0, 32'h41, 32'h40, "usb pending");
    rdm(MIT_OFF_CTL2, 32'h20, 32'h20, "cnt0 pending");
    wr(MIT_OFF_CTL0, 32'h49);
    wait_load(13'h000C);
    rdm(MIT_OFF_CTL0, 32'h41, 32'h00, "usb serviced");
    rdm(MIT_OFF_CTL2, 32'h20, 32'h20, "cnt0 waits");
    evp(10'h100);
    wait_load(13'h0123);
    wait_load(13'h001C);
    rdm(MIT_OFF_CTL2, 32'h20, 32'h00, "cnt0 serviced");
    evp(10'h100);
    wait_load(13'h0123);
    wr(MIT_OFF_CTL0, 32'h01);
    evp(10'h004);
    no_load();
    rdm(MIT_OFF_CTL0, 32'h41, 32'h41, "disabled flag");
  endtask
  task automatic t_full;
    slow <= 1'b1;
    wr(MIT_OFF_CTL3, 32'h02);
    for (int i = 0; i < 8; i++) begin
      wr(MIT_OFF_CTL0, 32'h01);
      evp(10'h002);
      wait_load(13'h0010);
    end
    wr(MIT_OFF_CTL0, 32'h01);
    evp(10'h002);
    no_load();
    rdm(MIT_OFF_CTL3, 32'h20, 32'h20, "held while full");
    evp(10'h100);
    wait_load(13'h0010);
    wait_load(13'h0010);
    for (int i = 0; i < 8; i++) begin
      evp(10'h100);
      wait_load(i == 7 ? 13'h0123 : 13'h0010);
    end
    slow <= 1'b0;
  endtask
  task automatic t_wake;
    int w0;
    int n;
    wr(MIT_OFF_CTL0, 32'h40);
    evp(10'h200);
    rdm(MIT_OFF_STAT, 32'h01, 32'h01, "asleep");
    w0 = n_wake;
    evp(10'h004);
    repeat (10) @(posedge hclk);
    chk(32'(n_wake - w0), 32'h0, "wake on set flag");
    evp(10'h080);
    n = 0;
    while (n_wake == w0 && n < 60) begin
      @(posedge hclk);
      n++;
    end
    tmo(n, 60);
    chk(32'(n_wake - w0), 32'h1, "wake on new flag");
    rdm(MIT_OFF_STAT, 32'h01, 32'h00, "awake");
  endtask
  task automatic t_tick;
    wr(MIT_OFF_TB0, 32'h07);
    wr(MIT_OFF_CTL1, 32'h0);
    repeat (600) @(posedge hclk);
    rdm(MIT_OFF_CTL1, 32'hC0, 32'h0, "stopped tick");
    tmeas(MIT_OFF_TB0, 2'h0, 3'h0, 32'h40, 256);
    tmeas(MIT_OFF_TB0, 2'h1, 3'h0, 32'h40, 1024);
    tmeas(MIT_OFF_TB0, 2'h0, 3'h1, 32'h40, 512);
    tmeas(MIT_OFF_TB1, 2'h2, 3'h0, 32'h80, 4096);
    tmeas(MIT_OFF_TB1, 2'h3, 3'h2, 32'h80, 16384);
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
    hsize = 3'h2;
    ext_irq_pin = 2'h0;
    {sleep_enter, ret_req, counter_overflow, usb_condition, frame_start, serial_done} = 10'h000;
    slow = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_edge();
    t_usb();
    t_vec();
    t_full();
    t_wake();
    t_tick();
    close_out();
  end
endmodule
`default_nettype wire
